// file: pkg/dma_consts.svh
/*
 * Constants of the DMA request source selection block: register indexes,
 * field positions, reset values and source codes.
 * Assumes it is included once per compilation unit by bare name.
 */
`ifndef DMA_CONSTS_SVH
`define DMA_CONSTS_SVH

// ****************************************************************
// Register indexes (byte address is four times the index)
// ****************************************************************
`define IDX_SRC_PTR0    10'h180
`define IDX_DST_PTR0    10'h184
`define IDX_COUNT0      10'h188
`define IDX_CTRL0       10'h18c
`define IDX_SRC_PTR1    10'h190
`define IDX_DST_PTR1    10'h194
`define IDX_COUNT1      10'h198
`define IDX_CTRL1       10'h19c
`define IDX_SRC_PTR2    10'h1a0
`define IDX_DST_PTR2    10'h1a4
`define IDX_COUNT2      10'h1a8
`define IDX_CTRL2       10'h1ac
`define IDX_SRC_PTR3    10'h1b0
`define IDX_DST_PTR3    10'h1b4
`define IDX_COUNT3      10'h1b8
`define IDX_CTRL3       10'h1bc
`define IDX_SEL2        10'h390
`define IDX_SEL3        10'h392
`define IDX_SEL0        10'h398
`define IDX_SEL1        10'h39a

// ****************************************************************
// Fields and reset values
// ****************************************************************
`define CTRL_ENABLE_BIT   0
`define CTRL_PENDING_BIT  4
`define SEL_EXT_BIT       5
`define SEL_SW_BIT        7
`define PTR_RESET         24'h00_0000
`define COUNT_RESET       16'h0000
`define CTRL_RESET        8'h00
`define SEL_RESET         6'h00
`define PIN_IDLE          4'hf

// ****************************************************************
// Source codes, extension bit clear
// ****************************************************************
`define SRC_IRQ_FALL      5'h00
`define SRC_SOFTWARE      5'h01
`define SRC_TIMER_A0      5'h02
`define SRC_TIMER_A4      5'h06
`define SRC_TIMER_B0      5'h07
`define SRC_TIMER_B2      5'h09
`define SRC_UART0_TX      5'h0a
`define SRC_UART0_RX      5'h0b
`define SRC_UART2_TX      5'h0c
`define SRC_UART2_RX      5'h0d
`define SRC_ADC           5'h0e
`define SRC_UART1_A       5'h0f
`define SRC_UART1_B       5'h10
`define SRC_UART5_TX      5'h11
`define SRC_UART7_RX      5'h16

// ****************************************************************
// Source codes, extension bit set
// ****************************************************************
`define SRCX_SSU3         5'h05
`define SRCX_BOTH_A       5'h06
`define SRCX_BOTH_B       5'h07
`define SRCX_TIMER_B4     5'h08
`define SRCX_TIMER_B5     5'h09
`define SRCX_UPPER_FALL   5'h10
`define SRCX_UPPER_BOTH   5'h11

// ****************************************************************
// Positions in the serial and timer B event vectors
// ****************************************************************
`define UART0_POS         3'd0
`define UART1_POS         3'd1
`define UART2_POS         3'd2
`define UART5_POS         3'd3
`define TIMER_B3_POS      3'd3
`define TIMER_B4_POS      3'd4
`define TIMER_B5_POS      3'd5

`endif

// file: pkg/dma_pkg.sv
/*
 * Types of the DMA request source selection block.
 * Assumes dma_consts.svh holds the numeric constants.
 */
package dma_pkg;

	// Bus slave states, one-hot
	typedef enum logic [2:0] {
		bus_idle   = 3'b001,
		bus_access = 3'b010,
		bus_resp   = 3'b100
	} bus_state_type;

	// Register kinds behind the decoder
	typedef enum logic [2:0] {
		reg_src = 3'd0,
		reg_dst = 3'd1,
		reg_cnt = 3'd2,
		reg_ctl = 3'd3,
		reg_sel = 3'd4
	} reg_kind_type;

	typedef struct packed {
		logic         hit;
		reg_kind_type kind;
		logic [1:0]   ch;
	} reg_hit_type;

	// AHB-Lite request from the master
	typedef struct packed {
		logic        hsel;
		logic [31:0] haddr;
		logic [1:0]  htrans;
		logic        hwrite;
		logic [2:0]  hsize;
		logic [31:0] hwdata;
		logic        hready;
	} ahb_req_type;

	// Peripheral event pulses; serial index 0..5 is UART 0,1,2,5,6,7
	typedef struct packed {
		logic [4:0] timer_a;
		logic [5:0] timer_b;
		logic [5:0] uart_tx;
		logic [5:0] uart_rx;
		logic [5:0] uart_ack;
		logic       sync_serial_unit3;
		logic       sync_serial_unit4;
		logic       adc;
	} periph_event_type;

	// Whole state of the block
	typedef struct packed {
		bus_state_type    bus;
		logic [9:0]       idx;
		logic             wr;
		logic             ok;
		logic [31:0]      rdata;
		logic [3:0][23:0] src_ptr;
		logic [3:0][23:0] dst_ptr;
		logic [3:0][15:0] count;
		logic [3:0][7:0]  ctrl;
		logic [3:0][5:0]  sel;
		logic [3:0]       pending;
		logic [3:0]       irq_prev;
		logic [3:0]       upper_prev;
	} dma_state_type;

endpackage : dma_pkg

// file: logic/dma_request_source_select.sv
/*
 * Request source selection and register file of a four channel DMA
 * controller, reached over AHB-Lite.
 * Assumes peripheral events are one-cycle pulses and pins are already
 * synchronous to clock; a channel acknowledges service on channel_service.
 */
// Register access over AHB-Lite was decided locally.
// Notes on behaviour
// - Four channels, each with own source select.
// - Code 0 falling pin edge; code 1 software.
// - Codes 2-6 timer A, 7-9 timer B.
// - Codes 0Ah, 0Ch UART0/UART2 transmit, all channels.
// - Code 0Bh UART0 receive; odd adds acknowledge.
// - Code 0Dh UART2 receive; odd adds acknowledge.
// - Code 0Eh converter request, every channel.
// - Code 0Fh even UART1 transmit, odd receive/ack.
// - Code 10h even UART1 receive, odd transmit.
// - Codes 11h-16h UART5-7 transmit/receive, odd acknowledge.
// - Extended 05h serial unit 3, odd only.
// - Extended 06h even both edges, odd unit 4.
// - Extended 07h even timer B3, odd both edges.
// - Extended 08h/09h timer B4/B5, even only.
// - Extended 10h falling edge of upper pin.
// - Extended 11h both edges of upper pin.
`include "dma_consts.svh"
`timescale 1ns/100ps
`default_nettype none

module dma_request_source_select (
	input  wire logic                      clock,
	input  wire logic                      rst,
	input  wire dma_pkg::ahb_req_type      bus,
	output logic                           hreadyout,
	output logic [31:0]                    hrdata,
	output logic                           hresp,
	input  wire dma_pkg::periph_event_type periph_event,
	input  wire logic [3:0]                channel_irq_pin_n,
	input  wire logic [3:0]                upper_irq_pin_n,
	input  wire logic [3:0]                channel_service,
	output logic [3:0]                     transfer_request
);

	// ************************************************************
	// Functions
	// ************************************************************

	// Register decode by word index
	function automatic dma_pkg::reg_hit_type decode(input logic [9:0] idx);
		dma_pkg::reg_hit_type d;
		d = '{1'b0, dma_pkg::reg_src, 2'd0};
		case (idx)
			`IDX_SRC_PTR0: d = '{1'b1, dma_pkg::reg_src, 2'd0};
			`IDX_DST_PTR0: d = '{1'b1, dma_pkg::reg_dst, 2'd0};
			`IDX_COUNT0:   d = '{1'b1, dma_pkg::reg_cnt, 2'd0};
			`IDX_CTRL0:    d = '{1'b1, dma_pkg::reg_ctl, 2'd0};
			`IDX_SRC_PTR1: d = '{1'b1, dma_pkg::reg_src, 2'd1};
			`IDX_DST_PTR1: d = '{1'b1, dma_pkg::reg_dst, 2'd1};
			`IDX_COUNT1:   d = '{1'b1, dma_pkg::reg_cnt, 2'd1};
			`IDX_CTRL1:    d = '{1'b1, dma_pkg::reg_ctl, 2'd1};
			`IDX_SRC_PTR2: d = '{1'b1, dma_pkg::reg_src, 2'd2};
			`IDX_DST_PTR2: d = '{1'b1, dma_pkg::reg_dst, 2'd2};
			`IDX_COUNT2:   d = '{1'b1, dma_pkg::reg_cnt, 2'd2};
			`IDX_CTRL2:    d = '{1'b1, dma_pkg::reg_ctl, 2'd2};
			`IDX_SRC_PTR3: d = '{1'b1, dma_pkg::reg_src, 2'd3};
			`IDX_DST_PTR3: d = '{1'b1, dma_pkg::reg_dst, 2'd3};
			`IDX_COUNT3:   d = '{1'b1, dma_pkg::reg_cnt, 2'd3};
			`IDX_CTRL3:    d = '{1'b1, dma_pkg::reg_ctl, 2'd3};
			`IDX_SEL0:     d = '{1'b1, dma_pkg::reg_sel, 2'd0};
			`IDX_SEL1:     d = '{1'b1, dma_pkg::reg_sel, 2'd1};
			`IDX_SEL2:     d = '{1'b1, dma_pkg::reg_sel, 2'd2};
			`IDX_SEL3:     d = '{1'b1, dma_pkg::reg_sel, 2'd3};
			default:       d = '{1'b0, dma_pkg::reg_src, 2'd0};
		endcase
		return d;
	endfunction : decode

	// Read value of a decoded register; unmapped reads as zero
	function automatic logic [31:0] read_word(input dma_pkg::dma_state_type s,
			input logic ok);
		dma_pkg::reg_hit_type d;
		logic [31:0]          r;
		d = decode(s.idx);
		r = 32'h0000_0000;
		if (ok && d.hit) begin
			case (d.kind)
				dma_pkg::reg_src: r[23:0] = s.src_ptr[d.ch];
				dma_pkg::reg_dst: r[23:0] = s.dst_ptr[d.ch];
				dma_pkg::reg_cnt: r[15:0] = s.count[d.ch];
				dma_pkg::reg_ctl: begin
					r[7:0] = s.ctrl[d.ch];
					r[`CTRL_PENDING_BIT] = s.pending[d.ch];
				end
				dma_pkg::reg_sel: r[5:0] = s.sel[d.ch];
				default:          r = 32'h0000_0000;
			endcase
		end
		return r;
	endfunction : read_word

	// Selected source event of one channel
	function automatic logic source_hit(input logic odd, input logic [5:0] sel,
			input dma_pkg::periph_event_type ev, input logic fall_i,
			input logic both_i, input logic fall_j, input logic both_j,
			input logic sw);
		logic [4:0] c;
		logic [4:0] off;
		logic [2:0] u;
		logic       r;
		c   = sel[4:0];
		off = c - `SRC_UART5_TX;
		u   = `UART5_POS + {1'b0, off[2:1]};
		r   = 1'b0;
		if (!sel[`SEL_EXT_BIT]) begin
			case (c)
				`SRC_IRQ_FALL: r = fall_i;
				`SRC_SOFTWARE: r = sw;
				`SRC_UART0_TX: r = ev.uart_tx[`UART0_POS];
				`SRC_UART2_TX: r = ev.uart_tx[`UART2_POS];
				`SRC_UART0_RX: r = ev.uart_rx[`UART0_POS]
						| (odd & ev.uart_ack[`UART0_POS]);
				`SRC_UART2_RX: r = ev.uart_rx[`UART2_POS]
						| (odd & ev.uart_ack[`UART2_POS]);
				`SRC_ADC:      r = ev.adc;
				`SRC_UART1_A:  r = odd ? (ev.uart_rx[`UART1_POS]
						| ev.uart_ack[`UART1_POS]) : ev.uart_tx[`UART1_POS];
				`SRC_UART1_B:  r = odd ? ev.uart_tx[`UART1_POS]
						: ev.uart_rx[`UART1_POS];
				default: begin
					if (c >= `SRC_TIMER_A0 && c <= `SRC_TIMER_A4)
						r = ev.timer_a[3'(c - `SRC_TIMER_A0)];
					else if (c >= `SRC_TIMER_B0 && c <= `SRC_TIMER_B2)
						r = ev.timer_b[3'(c - `SRC_TIMER_B0)];
					else if (c >= `SRC_UART5_TX && c <= `SRC_UART7_RX)
						r = off[0] ? (ev.uart_rx[u] | (odd & ev.uart_ack[u]))
							: ev.uart_tx[u];
					else
						r = 1'b0;
				end
			endcase
		end else begin
			case (c)
				`SRCX_SSU3:       r = odd & ev.sync_serial_unit3;
				`SRCX_BOTH_A:     r = odd ? ev.sync_serial_unit4 : both_i;
				`SRCX_BOTH_B:     r = odd ? both_i : ev.timer_b[`TIMER_B3_POS];
				`SRCX_TIMER_B4:   r = !odd & ev.timer_b[`TIMER_B4_POS];
				`SRCX_TIMER_B5:   r = !odd & ev.timer_b[`TIMER_B5_POS];
				`SRCX_UPPER_FALL: r = fall_j;
				`SRCX_UPPER_BOTH: r = both_j;
				default:          r = 1'b0;
			endcase
		end
		return r;
	endfunction : source_hit

	// ************************************************************
	// State and edge detection
	// ************************************************************

	dma_pkg::dma_state_type s_r;
	dma_pkg::dma_state_type s_nxt;
	logic [3:0]             sw;
	logic [3:0]             hit;
	logic [3:0]             fall_i;
	logic [3:0]             both_i;
	logic [3:0]             fall_j;
	logic [3:0]             both_j;

	// Pin edges against last sampled level; pins are active low
	assign fall_i = s_r.irq_prev & ~channel_irq_pin_n;
	assign both_i = s_r.irq_prev ^ channel_irq_pin_n;
	assign fall_j = s_r.upper_prev & ~upper_irq_pin_n;
	assign both_j = s_r.upper_prev ^ upper_irq_pin_n;

	// ************************************************************
	// Per channel source selection
	// ************************************************************

	// One selector per channel; odd channels see the second column
	for (genvar g = 0; g < 4; g++) begin : g_chan
		assign hit[g] = source_hit(g[0], s_r.sel[g], periph_event, fall_i[g],
				both_i[g], fall_j[g], both_j[g], sw[g]);
	end

	// ************************************************************
	// Next state: bus slave, registers, pending requests
	// ************************************************************

	// One wait state per transfer so reads see every earlier write
	always_comb begin
		dma_pkg::reg_hit_type d;
		d     = decode(s_r.idx);
		s_nxt = s_r;
		sw    = 4'h0;
		case (s_r.bus)
			dma_pkg::bus_idle, dma_pkg::bus_resp: begin
				if (bus.hsel && bus.htrans[1] && bus.hready) begin
					s_nxt.bus = dma_pkg::bus_access;
					s_nxt.idx = bus.haddr[11:2];
					s_nxt.wr  = bus.hwrite;
					s_nxt.ok  = (bus.haddr[31:12] == 20'h0_0000) && (bus.haddr[1:0] == 2'h0);
				end else begin
					s_nxt.bus = dma_pkg::bus_idle;
				end
			end
			dma_pkg::bus_access: begin
				s_nxt.bus   = dma_pkg::bus_resp;
				s_nxt.rdata = read_word(s_r, s_r.ok);
				if (s_r.wr && s_r.ok && d.hit) begin
					case (d.kind)
						dma_pkg::reg_src: s_nxt.src_ptr[d.ch] = bus.hwdata[23:0];
						dma_pkg::reg_dst: s_nxt.dst_ptr[d.ch] = bus.hwdata[23:0];
						dma_pkg::reg_cnt: s_nxt.count[d.ch]   = bus.hwdata[15:0];
						dma_pkg::reg_ctl: s_nxt.ctrl[d.ch]    = bus.hwdata[7:0];
						dma_pkg::reg_sel: begin
							s_nxt.sel[d.ch] = bus.hwdata[5:0];
							// Trigger judged against the code written with it
							sw[d.ch]        = bus.hwdata[`SEL_SW_BIT]
									& (bus.hwdata[5:0] == {1'b0, `SRC_SOFTWARE});
						end
						default: s_nxt.idx = s_r.idx;
					endcase
				end
			end
			default: s_nxt.bus = dma_pkg::bus_idle;
		endcase
		// Set wins over the service clear; a trigger write counts at once
		for (int i = 0; i < 4; i++) begin
			s_nxt.pending[i] = ((hit[i] | sw[i]) & s_r.ctrl[i][`CTRL_ENABLE_BIT])
					| (s_r.pending[i] & ~channel_service[i]);
		end
		s_nxt.irq_prev   = channel_irq_pin_n;
		s_nxt.upper_prev = upper_irq_pin_n;
	end

	// State register
	always_ff @(posedge clock) begin
		if (rst) begin
			s_r            <= '0;
			s_r.bus        <= dma_pkg::bus_idle;
			s_r.src_ptr    <= {4{`PTR_RESET}};
			s_r.dst_ptr    <= {4{`PTR_RESET}};
			s_r.count      <= {4{`COUNT_RESET}};
			s_r.ctrl       <= {4{`CTRL_RESET}};
			s_r.sel        <= {4{`SEL_RESET}};
			s_r.irq_prev   <= `PIN_IDLE;
			s_r.upper_prev <= `PIN_IDLE;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Outputs
	assign hreadyout        = (s_r.bus != dma_pkg::bus_access);
	assign hrdata           = s_r.rdata;
	assign hresp            = 1'b0;
	assign transfer_request = s_r.pending;

	// ************************************************************
	// Assertions
	// ************************************************************

	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	property p_pend_hold;
		s_r.pending[1] && !channel_service[1] |=> s_r.pending[1];
	endproperty
	a_pend_hold: assert property (p_pend_hold) else $error("pending lost");

	property p_hit_sets;
		hit[2] && s_r.ctrl[2][`CTRL_ENABLE_BIT] ##1 channel_service[2]
			|-> transfer_request[2];
	endproperty
	a_hit_sets: assert property (p_hit_sets) else $error("event not pended");

	property p_fall_pin;
		s_r.sel[0] == {1'b0, `SRC_IRQ_FALL} && $fell(channel_irq_pin_n[0])
			|-> hit[0];
	endproperty
	a_fall_pin: assert property (p_fall_pin) else $error("falling edge missed");

	property p_timer_a;
		s_r.sel[1] == 6'h02 |-> hit[1] == periph_event.timer_a[0];
	endproperty
	a_timer_a: assert property (p_timer_a) else $error("timer A0 select");

	property p_uart0_tx;
		s_r.sel[2] == 6'h0a |-> hit[2] == periph_event.uart_tx[0];
	endproperty
	a_uart0_tx: assert property (p_uart0_tx) else $error("UART0 transmit");

	property p_ack_even;
		s_r.sel[0] == 6'h0b && !periph_event.uart_rx[0] |-> !hit[0];
	endproperty
	a_ack_even: assert property (p_ack_even) else $error("ack on even");

	property p_ack_odd;
		s_r.sel[3] == 6'h0d && periph_event.uart_ack[2] |-> hit[3];
	endproperty
	a_ack_odd: assert property (p_ack_odd) else $error("ack on odd");

	property p_adc;
		s_r.sel[3] == 6'h0e |-> hit[3] == periph_event.adc;
	endproperty
	a_adc: assert property (p_adc) else $error("converter select");

	property p_uart1_odd;
		s_r.sel[1] == 6'h10 |-> hit[1] == periph_event.uart_tx[1];
	endproperty
	a_uart1_odd: assert property (p_uart1_odd) else $error("UART1 swap");

	property p_ssu3_even;
		s_r.sel[0] == 6'h25 |-> !hit[0];
	endproperty
	a_ssu3_even: assert property (p_ssu3_even) else $error("unit 3 even");

	property p_b4_odd;
		s_r.sel[1] == 6'h28 |-> !hit[1];
	endproperty
	a_b4_odd: assert property (p_b4_odd) else $error("timer B4 odd");

	property p_one_wait;
		!hreadyout |=> hreadyout;
	endproperty
	a_one_wait: assert property (p_one_wait) else $error("wait too long");

	property p_sw_trigger;
		sw[0] && s_r.ctrl[0][`CTRL_ENABLE_BIT] |=> transfer_request[0];
	endproperty
	a_sw_trigger: assert property (p_sw_trigger) else $error("software trigger lost");

	property p_uart5_rx;
		s_r.sel[3] == 6'h12 |-> hit[3] == (periph_event.uart_rx[3] | periph_event.uart_ack[3]);
	endproperty
	a_uart5_rx: assert property (p_uart5_rx) else $error("UART5 receive odd");

	property p_both_odd;
		s_r.sel[1] == 6'h27 |-> hit[1] == $changed(channel_irq_pin_n[1]);
	endproperty
	a_both_odd: assert property (p_both_odd) else $error("both edges odd");

	property p_upper_fall;
		s_r.sel[2] == {1'b1, `SRCX_UPPER_FALL} && $fell(upper_irq_pin_n[2]) |-> hit[2];
	endproperty
	a_upper_fall: assert property (p_upper_fall) else $error("upper pin fall missed");

endmodule : dma_request_source_select

`default_nettype wire

// file: bench/event_source_model.sv
/*
 * Behavioural model of the on-chip event sources and interrupt pins.
 * Assumes the bench asks for one event pulse per fire request.
 */
`timescale 1ns/100ps
`default_nettype none

module event_source_model (
	input  wire logic                      clock,
	input  wire logic                      rst,
	input  wire logic                      fire,
	input  wire dma_pkg::periph_event_type fire_ev,
	input  wire logic [3:0]                irq_low,
	input  wire logic [3:0]                upper_low,
	output logic [3:0]                     channel_irq_pin_n,
	output logic [3:0]                     upper_irq_pin_n,
	output dma_pkg::periph_event_type      periph_event
);
	logic fire_r;

	// Last fire level, so a held request still yields one pulse
	always_ff @(posedge clock) begin
		fire_r <= rst ? 1'b0 : fire;
	end

	// Events are single-cycle pulses; pins idle high in reset
	always_comb begin
		periph_event = (fire && !fire_r) ? fire_ev : '0;
		channel_irq_pin_n = rst ? 4'hf : ~irq_low;
		upper_irq_pin_n = rst ? 4'hf : ~upper_low;
	end
endmodule : event_source_model
`default_nettype wire

// file: bench/dma_request_source_select_bench.sv
/*
 * Self-checking bench of the DMA request source selection block.
 * Assumes the design package, constants header and event model.
 */
`include "dma_consts.svh"
`timescale 1ns/100ps
`default_nettype none

module dma_request_source_select_bench;
	localparam logic [31:0] reg_mask [4] = '{32'h00ff_ffff, 32'h00ff_ffff, 32'h0000_ffff,
		32'h0000_00ef};
	logic                      clock;
	logic                      rst;
	dma_pkg::ahb_req_type      mst;
	dma_pkg::ahb_req_type      bus_in;
	logic                      hreadyout;
	logic [31:0]               hrdata;
	logic                      hresp;
	dma_pkg::periph_event_type periph_event;
	dma_pkg::periph_event_type fire_ev;
	logic                      fire;
	logic [3:0]                irq_low;
	logic [3:0]                upper_low;
	logic [3:0]                channel_irq_pin_n;
	logic [3:0]                upper_irq_pin_n;
	logic [3:0]                channel_service;
	logic [3:0]                transfer_request;
	int                        fails;
	int                        check_count;
	logic [31:0]               q;

	dma_request_source_select dma_request_source_select_inst (
		.clock(clock), .rst(rst), .bus(bus_in), .hreadyout(hreadyout), .hrdata(hrdata),
		.hresp(hresp), .periph_event(periph_event), .channel_irq_pin_n(channel_irq_pin_n),
		.upper_irq_pin_n(upper_irq_pin_n), .channel_service(channel_service),
		.transfer_request(transfer_request));

	event_source_model event_source_model_inst (
		.clock(clock), .rst(rst), .fire(fire), .fire_ev(fire_ev), .irq_low(irq_low),
		.upper_low(upper_low), .channel_irq_pin_n(channel_irq_pin_n),
		.upper_irq_pin_n(upper_irq_pin_n), .periph_event(periph_event));

	// ****************************************************************
	// Helpers
	// ****************************************************************
	// Single slave, so its ready is the bus ready
	always_comb begin
		bus_in = mst;
		bus_in.hready = hreadyout;
	end

	function automatic logic [9:0] reg_idx(input int ch, input int k);
		return `IDX_SRC_PTR0 + 10'(16 * ch + 4 * k);
	endfunction : reg_idx

	function automatic logic [9:0] sel_idx(input int ch);
		case (ch)
			0: return `IDX_SEL0;
			1: return `IDX_SEL1;
			2: return `IDX_SEL2;
			default: return `IDX_SEL3;
		endcase
	endfunction : sel_idx

	// Whether event set e requests on channel ch for extension x, code c
	function automatic logic hit(input int ch, input logic x, input logic [4:0] c,
			input dma_pkg::periph_event_type e);
		logic odd;
		int   u;
		odd = ch[0];
		u = (int'(c) - 17) / 2 + 3;
		if (x) begin
			case (c)
				5'h05: return odd & e.sync_serial_unit3;
				5'h06: return odd & e.sync_serial_unit4;
				5'h07: return !odd & e.timer_b[3];
				5'h08, 5'h09: return !odd & e.timer_b[c - 5'h04];
				default: return 1'b0;
			endcase
		end
		case (c)
			5'h02, 5'h03, 5'h04, 5'h05, 5'h06: return e.timer_a[c - 5'h02];
			5'h07, 5'h08, 5'h09: return e.timer_b[c - 5'h07];
			5'h0a: return e.uart_tx[0];
			5'h0b: return e.uart_rx[0] | (odd & e.uart_ack[0]);
			5'h0c: return e.uart_tx[2];
			5'h0d: return e.uart_rx[2] | (odd & e.uart_ack[2]);
			5'h0e: return e.adc;
			5'h0f: return odd ? (e.uart_rx[1] | e.uart_ack[1]) : e.uart_tx[1];
			5'h10: return odd ? e.uart_tx[1] : e.uart_rx[1];
			5'h11, 5'h13, 5'h15: return e.uart_tx[u];
			5'h12, 5'h14, 5'h16: return e.uart_rx[u] | (odd & e.uart_ack[u]);
			default: return 1'b0;
		endcase
	endfunction : hit

	task automatic chk_reg(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : chk_reg

	task automatic chk_req(input logic [3:0] exp);
		check_count++;
		if (transfer_request !== exp) begin
			fails++;
			$display("MISMATCH transfer_request expected %h seen %h", exp, transfer_request);
		end
	endtask : chk_req

	// One AHB single transfer; ready and read data are taken at the rising edge
	task automatic xfer(input logic wr, input logic [9:0] idx, input logic [31:0] d);
		mst.hsel <= 1'b1;
		mst.haddr <= {20'h0_0000, idx, 2'b00};
		mst.htrans <= 2'b10;
		mst.hwrite <= wr;
		mst.hsize <= 3'b010;
		do @(posedge clock); while (hreadyout !== 1'b1);
		mst.hsel <= 1'b0;
		mst.htrans <= 2'b00;
		mst.hwdata <= d;
		do @(posedge clock); while (hreadyout !== 1'b1);
		q = hrdata;
		chk_reg("hresp", 32'h0000_0000, {31'h0000_0000, hresp});
	endtask : xfer

	// Event pulse for one cycle and new pin levels that stay set, then look after the next edge
	task automatic stim(input dma_pkg::periph_event_type ev, input logic [3:0] il,
			input logic [3:0] ul);
		@(posedge clock);
		fire <= 1'b1;
		fire_ev <= ev;
		irq_low <= il;
		upper_low <= ul;
		@(posedge clock);
		fire <= 1'b0;
		#1;
	endtask : stim

	task automatic serve;
		@(posedge clock);
		channel_service <= 4'hf;
		@(posedge clock);
		channel_service <= 4'h0;
		#1;
		chk_req(4'h0);
	endtask : serve

	task automatic conclude;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : conclude

	// ****************************************************************
	// Clock, watchdog and tests
	// ****************************************************************
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	initial begin
		#200000;
		fails++;
		conclude();
	end

	initial begin
		logic [31:0]               r;
		logic [3:0]                m;
		logic [4:0]                c;
		dma_pkg::periph_event_type e;
		fails = 0;
		check_count = 0;
		mst = '0;
		fire = 1'b0;
		fire_ev = '0;
		irq_low = 4'h0;
		upper_low = 4'h0;
		channel_service = 4'h0;
		rst = 1'b1;
		void'($urandom(32'h5774));
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		// Reset values, then random store and read back of every register
		for (int ch = 0; ch < 4; ch++) begin
			for (int k = 0; k < 4; k++) begin
				xfer(1'b0, reg_idx(ch, k), 32'h0000_0000);
				chk_reg("register reset", 32'h0000_0000, q);
				r = $urandom;
				xfer(1'b1, reg_idx(ch, k), r);
				xfer(1'b0, reg_idx(ch, k), 32'h0000_0000);
				chk_reg("register readback", r & reg_mask[k], q);
			end
			xfer(1'b0, sel_idx(ch), 32'h0000_0000);
			chk_reg("select reset", 32'h0000_0000, q);
			r = $urandom & 32'h0000_007f;
			xfer(1'b1, sel_idx(ch), r);
			xfer(1'b0, sel_idx(ch), 32'h0000_0000);
			chk_reg("select readback", r & 32'h0000_003f, q);
		end
		xfer(1'b1, 10'h1c0, 32'hffff_ffff);
		xfer(1'b0, 10'h1c0, 32'h0000_0000);
		chk_reg("unmapped read", 32'h0000_0000, q);
		// Every select value on every channel, random and full event sets
		for (int ch = 0; ch < 4; ch++) begin
			for (int k = 0; k < 4; k++)
				xfer(1'b1, reg_idx(k, 3), (k == ch) ? 32'h0000_0001 : 32'h0000_0000);
			for (int s = 0; s < 64; s++) begin
				xfer(1'b1, sel_idx(ch), 32'(s));
				for (int n = 0; n < 3; n++) begin
					e = dma_pkg::periph_event_type'((n == 2) ? 32'hffff_ffff : 32'h1 << ($urandom % 32));
					stim(e, 4'h0, 4'h0);
					chk_req(hit(ch, s[5], s[4:0], e) ? 4'(1 << ch) : 4'h0);
					serve();
				end
			end
		end
		// Pin edges: falling only or both edges, own and upper pins
		for (int ch = 0; ch < 4; ch++) begin
			m = 4'(1 << ch);
			for (int k = 0; k < 4; k++)
				xfer(1'b1, reg_idx(k, 3), (k == ch) ? 32'h0000_0001 : 32'h0000_0000);
			for (int md = 0; md < 4; md++) begin
				c = (md == 0) ? 5'h00 : (md == 1) ? (ch[0] ? 5'h07 : 5'h06) : (md == 2) ? 5'h10 : 5'h11;
				xfer(1'b1, sel_idx(ch), {26'h000_0000, md != 0, c});
				stim('0, (md < 2) ? m : 4'h0, (md >= 2) ? m : 4'h0);
				chk_req(m);
				serve();
				stim('0, 4'h0, 4'h0);
				chk_req(md[0] ? m : 4'h0);
				serve();
			end
			// Software trigger only with its own code; pending held and visible
			xfer(1'b1, sel_idx(ch), 32'h0000_0082);
			xfer(1'b0, reg_idx(ch, 3), 32'h0000_0000);
			chk_reg("control no trigger", 32'h0000_0001, q);
			xfer(1'b1, sel_idx(ch), 32'h0000_0081);
			xfer(1'b0, reg_idx(ch, 3), 32'h0000_0000);
			chk_reg("control pending", 32'h0000_0011, q);
			xfer(1'b0, sel_idx(ch), 32'h0000_0000);
			chk_reg("select trigger bit", 32'h0000_0001, q);
			chk_req(m);
			serve();
		end
		conclude();
	end
endmodule : dma_request_source_select_bench
`default_nettype wire
